// >>> verilog/cbt_master.sv
// Bus master port: arbitration, address strobe, burst data, retry and abort
`timescale 1ns/1ps
// How it works
// - Next doubleword is driven two cycles after ready is seen.
// - Relinquish-and-retry: drop bus, rerequest, reissue same operation.
// - Plain retry keeps bus busy asserted and reissues without arbitration.
// - At least one idle cycle after any retry before the next strobe.
// - Any error acknowledgment aborts the transaction at once, any beat.
// - No grant after reset; request and wait for grant first.
// - Request is dropped as soon as the grant is received.
// - Locked sequences hold bus busy until an operation issued without lock completes, read or write, or any operation ends in error or relinquish.
module cbt_master #(
    parameter int DATA_W = cbt_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rstn,
    // User command port
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire logic              cmd_write,
    input  wire logic              cmd_burst,
    input  wire logic              cmd_lock,
    input  wire logic              snoop_slow,
    input  wire logic [DATA_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [1:0]        wr_beat_idx_unused,
    output logic [1:0]             wr_beat,
    output logic                   rd_valid,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   done,
    output logic [1:0]             done_result,
    output logic                   done_shared,
    // Bus pins; request, busy and strobe outputs active low, output enables active high
    output logic                   bus_request_n,
    output logic                   bus_busy_n,
    output logic                   bus_busy_oe,
    output logic                   addr_strobe_n,
    output logic                   addr_strobe_oe,
    output logic [DATA_W-1:0]      mux_addr_data_o,
    output logic                   mux_addr_data_oe,
    input  wire logic [DATA_W-1:0] mux_addr_data_i,
    input  wire logic              ready_ack_n,
    input  wire logic              retry_ack_n,
    input  wire logic              error_ack_n,
    input  wire logic              shared_snoop_n,
    input  wire logic              inhibit_snoop_n,
    input  wire logic              bus_grant_n
);
    typedef enum logic [2:0] {
        CBT_IDLE, CBT_REQ, CBT_ADDR, CBT_DATA, CBT_DEAD, CBT_HOLD
    } cbt_fsm_t;

    typedef struct packed {
        cbt_fsm_t          fsm;
        logic              req;
        logic              busy;
        logic              strobe;
        logic              drive;
        logic [DATA_W-1:0] bus_out;
        logic [DATA_W-1:0] addr;
        logic              write;
        logic              burst;
        logic              lock;
        logic              slow;
        logic              locked_hold;
        logic [2:0]        beat;
        logic [3:0]        acyc;
        logic              shared;
        logic              rd_valid;
        logic [DATA_W-1:0] rd_data;
        logic              done;
        logic [1:0]        result;
    } cbt_master_t;

    cbt_master_t state;
    cbt_master_t next_state;
    cbt_ack_if   ack ();
    logic [DATA_W-1:0] din_meta;
    logic [DATA_W-1:0] din;

    // Acknowledgment pins pass two flops before use
    cbt_ack_sync u_sync (
        .clock           (clock),
        .rstn            (rstn),
        .ready_ack_n     (ready_ack_n),
        .retry_ack_n     (retry_ack_n),
        .error_ack_n     (error_ack_n),
        .shared_snoop_n  (shared_snoop_n),
        .inhibit_snoop_n (inhibit_snoop_n),
        .bus_grant_n     (bus_grant_n),
        .ack             (ack)
    );

    // Read data aligned with the synchronised acknowledgments
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            din_meta <= '0;
            din      <= '0;
        end else begin
            din_meta <= mux_addr_data_i;
            din      <= din_meta;
        end
    end

    // Main sequencer
    always_comb begin
        next_state          = state;
        next_state.done     = 1'b0;
        next_state.rd_valid = 1'b0;
        next_state.strobe   = 1'b0;
        if (state.acyc != 4'hf) begin
            next_state.acyc = state.acyc + 4'h1;
        end
        case (state.fsm)
            CBT_IDLE: begin
                if (state.locked_hold) begin
                    next_state.busy = 1'b1;
                end else begin
                    next_state.busy  = 1'b0;
                    next_state.drive = 1'b0;
                end
                if (cmd_valid) begin
                    next_state.addr  = cmd_addr;
                    next_state.write = cmd_write;
                    next_state.burst = cmd_burst;
                    next_state.lock  = cmd_lock;
                    next_state.slow  = snoop_slow;
                    if (state.locked_hold) begin
                        next_state.fsm = CBT_ADDR;
                    end else begin
                        next_state.req = 1'b1;
                        next_state.fsm = CBT_REQ;
                    end
                end
            end
            CBT_REQ: begin
                if (ack.grant) begin
                    next_state.req = 1'b0;
                    next_state.fsm = CBT_ADDR;
                end
            end
            CBT_ADDR: begin
                // Address cycle: strobe, busy and address on the muxed lines
                next_state.busy    = 1'b1;
                next_state.strobe  = 1'b1;
                next_state.drive   = 1'b1;
                next_state.bus_out = state.addr;
                next_state.beat    = 3'h0;
                next_state.acyc    = 4'h0;
                next_state.shared  = 1'b0;
                next_state.fsm     = CBT_DATA;
            end
            CBT_DATA: begin
                if (state.write) begin
                    next_state.bus_out = wr_data;
                end else begin
                    next_state.drive = 1'b0;
                end
                // The synchroniser shows the pin two cycles late, so A+2 is judged at count four
                if (state.acyc == (state.slow ? cbt_pkg::SNOOP_SLOW : cbt_pkg::SNOOP_FAST) + cbt_pkg::SYNC_LAT
                        && ack.shared) begin
                    next_state.shared = 1'b1;
                end
                if (ack.error) begin
                    next_state.drive       = 1'b0;
                    next_state.result      = cbt_pkg::RESULT_ERR;
                    next_state.done        = 1'b1;
                    next_state.locked_hold = 1'b0;
                    next_state.fsm         = CBT_IDLE;
                end else if (ack.relinquish) begin
                    next_state.drive       = 1'b0;
                    next_state.busy        = 1'b0;
                    next_state.locked_hold = 1'b0;
                    next_state.fsm         = CBT_HOLD;
                end else if (ack.retry) begin
                    next_state.drive = 1'b0;
                    next_state.fsm   = CBT_DEAD;
                end else if (ack.ready) begin
                    if (!state.write) begin
                        next_state.rd_valid = 1'b1;
                        next_state.rd_data  = din;
                    end
                    next_state.beat = state.beat + 3'h1;
                    if (!state.burst || state.beat == cbt_pkg::BEAT_MAX) begin
                        next_state.drive       = 1'b0;
                        next_state.result      = cbt_pkg::RESULT_OK;
                        next_state.done        = 1'b1;
                        next_state.locked_hold = state.lock;
                        next_state.fsm         = CBT_IDLE;
                    end
                end
                // No ready means wait state: keep data on the lines
            end
            CBT_DEAD: begin
                // One idle cycle with busy held before reissue
                next_state.busy = 1'b1;
                next_state.fsm  = CBT_ADDR;
            end
            CBT_HOLD: begin
                // Bus released; rearbitrate then reissue the same operation
                next_state.req = 1'b1;
                next_state.fsm = CBT_REQ;
            end
            default: begin
                next_state.fsm = CBT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state     <= '0;
            state.fsm <= CBT_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Outputs
    assign cmd_ready        = (state.fsm == CBT_IDLE);
    assign wr_beat          = state.beat[1:0];
    assign rd_valid         = state.rd_valid;
    assign rd_data          = state.rd_data;
    assign done             = state.done;
    assign done_result      = state.result;
    assign done_shared      = state.shared;
    assign bus_request_n    = !state.req;
    assign bus_busy_n       = !state.busy;
    assign bus_busy_oe      = state.busy;
    assign addr_strobe_n    = !state.strobe;
    assign addr_strobe_oe   = state.busy;
    assign mux_addr_data_o  = state.bus_out;
    assign mux_addr_data_oe = state.drive;
endmodule

// >>> verilog/cbt_pkg.sv
// Shared constants and types for the coherent bus master port
package cbt_pkg;
    localparam int          DATA_W      = 64;
    localparam int          BURST_BEATS = 4;          // 32-byte burst of 8-byte doublewords
    localparam logic [2:0]  BEAT_MAX    = 3'h3;
    localparam logic [1:0]  ACK_NONE    = 2'h0;
    localparam logic [1:0]  ACK_READY   = 2'h1;
    localparam logic [1:0]  ACK_RETRY   = 2'h2;
    localparam logic [1:0]  ACK_RELINQ  = 2'h3;
    localparam logic [3:0]  SNOOP_FAST  = 4'h2;       // Shared/inhibit sample cycle A+2
    localparam logic [3:0]  SNOOP_SLOW  = 4'h7;       // Slow option A+7
    localparam logic [3:0]  SYNC_LAT    = 4'h2;       // Pin to decoded acknowledgment delay
    localparam logic [1:0]  RESULT_OK   = 2'h0;
    localparam logic [1:0]  RESULT_ERR  = 2'h1;
    localparam logic [1:0]  RESULT_ABRT = 2'h2;

    typedef enum logic [1:0] {
        CBT_ERR_NONE,
        CBT_ERR_UNCORR,
        CBT_ERR_FIRST,
        CBT_ERR_SECOND
    } cbt_err_t;
endpackage

// >>> verilog/cbt_ack_if.sv
// Decoded acknowledgment bundle passed from the decoder to the master core
`timescale 1ns/1ps
interface cbt_ack_if;
    logic ready;
    logic retry;
    logic relinquish;
    logic error;
    logic shared;
    logic inhibit;
    logic grant;
    modport dec  (output ready, output retry, output relinquish, output error,
                  output shared, output inhibit, output grant);
    modport core (input ready, input retry, input relinquish, input error,
                  input shared, input inhibit, input grant);
endinterface

// >>> verilog/cbt_ack_sync.sv
// Two-flop synchroniser and decoder for the bus acknowledgment pins
`timescale 1ns/1ps
module cbt_ack_sync (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rstn,
    // Raw bus pins, active low
    input  wire logic       ready_ack_n,
    input  wire logic       retry_ack_n,
    input  wire logic       error_ack_n,
    input  wire logic       shared_snoop_n,
    input  wire logic       inhibit_snoop_n,
    input  wire logic       bus_grant_n,
    // Decoded, active high
    cbt_ack_if.dec          ack
);
    typedef struct packed {
        logic [5:0] meta;
        logic [5:0] sync;
    } cbt_sync_t;

    cbt_sync_t state;
    cbt_sync_t next_state;

    // First stage feeds only the second stage
    always_comb begin
        next_state      = state;
        next_state.meta = ~{ready_ack_n, retry_ack_n, error_ack_n,
                            shared_snoop_n, inhibit_snoop_n, bus_grant_n};
        next_state.sync = state.meta;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Encoding: ready+retry both low means relinquish-and-retry; error alone
    // or with ready/retry maps the three error kinds, all treated as abort
    assign ack.error      = state.sync[3];
    assign ack.relinquish = !state.sync[3] && state.sync[5] && state.sync[4];
    assign ack.ready      = !state.sync[3] && state.sync[5] && !state.sync[4];
    assign ack.retry      = !state.sync[3] && !state.sync[5] && state.sync[4];
    assign ack.shared     = state.sync[2];
    assign ack.inhibit    = state.sync[1];
    assign ack.grant      = state.sync[0];
endmodule

// >>> test/cbt_master_assertions.sv
// Pin-level checks on the bus master port
`timescale 1ns/1ps
module cbt_master_assertions (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rstn,
    // User side
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic       cmd_lock,
    input wire logic       done,
    input wire logic [1:0] done_result,
    // Bus pins
    input wire logic       bus_request_n,
    input wire logic       bus_busy_n,
    input wire logic       addr_strobe_n,
    input wire logic       mux_addr_data_oe,
    input wire logic       ready_ack_n,
    input wire logic       retry_ack_n,
    input wire logic       error_ack_n,
    input wire logic       bus_grant_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic lock_q;
    // Lock flag of the op in flight, kept until the next take so it still holds at done
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) lock_q <= 1'b0;
        else if (cmd_valid && cmd_ready) lock_q <= cmd_lock;
    end
    property p_grant; $fell(addr_strobe_n) && $past(bus_busy_n) |-> $past(!bus_grant_n, 2); endproperty
    a_grant: assert property (p_grant) else $error("strobe without grant");
    property p_drop; !bus_request_n && !bus_grant_n |-> ##[1:4] bus_request_n; endproperty
    a_drop: assert property (p_drop) else $error("request kept after grant");
    property p_strobe; $fell(addr_strobe_n) |-> !bus_busy_n && mux_addr_data_oe ##1 addr_strobe_n; endproperty
    a_strobe: assert property (p_strobe) else $error("bad address cycle");
    property p_keep; !retry_ack_n && ready_ack_n && error_ack_n |-> ##1 !bus_busy_n [*4]; endproperty
    a_keep: assert property (p_keep) else $error("busy dropped on retry");
    property p_dead; !retry_ack_n |-> ##1 addr_strobe_n [*3]; endproperty
    a_dead: assert property (p_dead) else $error("no dead cycle");
    property p_relinq; !retry_ack_n && !ready_ack_n |-> ##[1:5] bus_busy_n; endproperty
    a_relinq: assert property (p_relinq) else $error("bus kept on relinquish");
    property p_abort; !error_ack_n |-> ##[1:5] (done && done_result == cbt_pkg::RESULT_ERR); endproperty
    a_abort: assert property (p_abort) else $error("error not aborted");
    property p_lock; done && lock_q |=> !bus_busy_n; endproperty
    a_lock: assert property (p_lock) else $error("busy dropped in lock");
    c_retry: cover property (!retry_ack_n && ready_ack_n);
    c_relinq: cover property (!retry_ack_n && !ready_ack_n);
    c_lock: cover property (done && lock_q);
endmodule

// >>> test/cbt_bus_model.sv
// Far side: parking arbiter, memory slave with chosen acks, snooping cache
`timescale 1ns/1ps
module cbt_bus_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Scenario controls; ACK_NONE asks for an error
    input  wire logic [1:0]  ack_kind,
    input  wire logic [2:0]  ack_beat,
    input  wire logic [2:0]  beats,
    input  wire logic        shr,
    input  wire logic        slow,
    // Bus
    input  wire logic        bus_request_n,
    input  wire logic        addr_strobe_n,
    input  wire logic [63:0] mad_o,
    output logic [63:0]      mad_i,
    output logic             ready_ack_n,
    output logic             retry_ack_n,
    output logic             error_ack_n,
    output logic             shared_snoop_n,
    output logic             bus_grant_n,
    output logic [63:0]      wr_q [4],
    output logic [63:0]      addr_q
);
    int   t;   // Cycle after the strobe; zero when idle
    int   b;   // Next beat
    logic odd; // Special ack given once per op
    // Acks spaced four cycles apart, since the master sees pins two cycles late
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {t, b} <= '0;
            odd <= 1'b0;
            {ready_ack_n, retry_ack_n, error_ack_n, shared_snoop_n, bus_grant_n} <= 5'h1f;
            {mad_i, addr_q} <= '0;
        end else begin
            {ready_ack_n, retry_ack_n, error_ack_n, shared_snoop_n} <= 4'hf;
            mad_i <= ~mad_i; // no owner; idle lines toggle
            if (!bus_request_n) bus_grant_n <= 1'b0;
            if (shr && t == (slow ? 6 : 1)) shared_snoop_n <= 1'b0;
            // Write beat is taken at the close of the cycle in which ready stands
            if (!ready_ack_n && retry_ack_n && b > 0) wr_q[b - 1] <= mad_o;
            if (!addr_strobe_n) begin
                t <= 1;
                b <= 0;
                addr_q <= mad_o;
                for (int k = 0; k < 4; k++) wr_q[k] <= '0; // Stale beats must not pass a later check
            end else if (t > 0) t <= t + 1;
            if (t > 0 && t == (slow ? 6 : 1) + 4 * b) begin
                if (!odd && b == ack_beat && ack_kind != cbt_pkg::ACK_READY) begin
                    odd <= 1'b1;
                    retry_ack_n <= ack_kind == cbt_pkg::ACK_NONE;
                    ready_ack_n <= ack_kind != cbt_pkg::ACK_RELINQ;
                    error_ack_n <= ack_kind != cbt_pkg::ACK_NONE;
                    t <= 0;
                end else begin
                    ready_ack_n <= 1'b0;
                    mad_i <= addr_q + 64'(b);
                    b <= b + 1;
                    if (b + 1 == beats) t <= 0;
                    if (b + 1 == beats) odd <= 1'b0;
                end
            end
        end
    end
endmodule

// >>> test/coherent_bus_transaction_protocol_tb.sv
// Bench for the bus master port against the bus model
`timescale 1ns/1ps
module coherent_bus_transaction_protocol_tb;
    localparam logic [63:0] PAT = 64'ha5a5_0000_0000_0000; // Write beat k carries PAT+k
    logic        clock, rstn, cmd_valid, cmd_write, cmd_burst, cmd_lock, snoop_slow, shr, shq;
    logic        cmd_ready, rd_valid, done, done_shared, bus_request_n, bus_busy_n, bus_busy_oe;
    logic        addr_strobe_n, addr_strobe_oe, mux_addr_data_oe, ready_ack_n, retry_ack_n;
    logic        error_ack_n, shared_snoop_n, bus_grant_n;
    logic [1:0]  wr_beat, done_result, ack_kind, res;
    logic [2:0]  ack_beat, beats;
    logic [63:0] cmd_addr, wr_data, rd_data, mux_addr_data_o, mux_addr_data_i, addr_q, rdq [4], wr_q [4];
    int          bad_count = 0, n_tests = 0, strobes, reqs, rdv;
    assign wr_data = PAT | 64'(wr_beat);
    cbt_master dut_u (.clock, .rstn, .cmd_valid, .cmd_ready, .cmd_write, .cmd_burst, .cmd_lock,
        .snoop_slow, .cmd_addr, .wr_data, .wr_beat_idx_unused(2'h0), .wr_beat, .rd_valid, .rd_data,
        .done, .done_result, .done_shared, .bus_request_n, .bus_busy_n, .bus_busy_oe, .addr_strobe_n,
        .addr_strobe_oe, .mux_addr_data_o, .mux_addr_data_oe, .mux_addr_data_i, .ready_ack_n,
        .retry_ack_n, .error_ack_n, .shared_snoop_n, .inhibit_snoop_n(1'b1), .bus_grant_n);
    cbt_bus_model bus_u (.clock, .rstn, .ack_kind, .ack_beat, .beats, .shr, .slow(snoop_slow),
        .bus_request_n, .addr_strobe_n, .mad_o(mux_addr_data_o), .mad_i(mux_addr_data_i), .ready_ack_n,
        .retry_ack_n, .error_ack_n, .shared_snoop_n, .bus_grant_n, .wr_q, .addr_q);
    // Clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Bus activity counted per op
    always @(posedge clock) begin
        if (addr_strobe_n === 1'b0) strobes++;
        if (rd_valid === 1'b1) rdq[rdv[1:0]] = rd_data;
        if (rd_valid === 1'b1) rdv++;
    end
    always @(negedge bus_request_n) reqs++;
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One command, bounded wait for done; result kept as it stands in the done cycle
    task automatic op(input logic w, bu, lk, sl, input logic [1:0] k, input logic [2:0] kb, input logic sh);
        int n;
        {cmd_write, cmd_burst, cmd_lock, snoop_slow, ack_kind, ack_beat, shr} = {w, bu, lk, sl, k, kb, sh};
        beats = bu ? 3'h4 : 3'h1;
        cmd_addr = cmd_addr + 64'h20;
        strobes = 0;
        reqs = 0;
        rdv = 0;
        cmd_valid = 1'b1;
        @(posedge clock);
        #1 cmd_valid = 1'b0;
        for (n = 0; n < 300 && done !== 1'b1; n++) begin
            @(posedge clock);
            #1;
        end
        res = done_result;
        shq = done_shared;
        chk(n < 300, "no done");
        @(posedge clock);
        #1;
    endtask
    task automatic t_write;
        op(1, 1, 0, 0, cbt_pkg::ACK_READY, 0, 0);
        for (int k = 0; k < 4; k++) chk(wr_q[k] === (PAT | 64'(k)), "write beat");
        chk(addr_q === cmd_addr && reqs == 1 && res === cbt_pkg::RESULT_OK && shq === 1'b0, "write");
    endtask
    task automatic t_read;
        op(0, 1, 0, 0, cbt_pkg::ACK_READY, 0, 1);
        chk(rdv == 4 && res === cbt_pkg::RESULT_OK && shq === 1'b1, "read burst");
        for (int k = 0; k < 4; k++) chk(rdq[k] === cmd_addr + 64'(k), "read beat");
    endtask
    task automatic t_retry;
        op(0, 0, 0, 0, cbt_pkg::ACK_RETRY, 0, 0);
        chk(strobes == 2 && reqs == 1 && res === cbt_pkg::RESULT_OK, "retry");
        op(1, 0, 0, 0, cbt_pkg::ACK_RELINQ, 0, 0);
        chk(strobes == 2 && reqs == 2 && wr_q[0] === PAT && res === cbt_pkg::RESULT_OK, "relinquish");
    endtask
    task automatic t_error;
        op(0, 1, 0, 0, cbt_pkg::ACK_NONE, 2, 0);
        chk(rdv == 2 && res === cbt_pkg::RESULT_ERR, "error abort");
    endtask
    task automatic t_lock;
        op(0, 0, 1, 0, cbt_pkg::ACK_READY, 0, 0);
        chk(bus_busy_n === 1'b0 && bus_busy_oe === 1'b1, "lock busy");
        op(1, 0, 0, 0, cbt_pkg::ACK_READY, 0, 0);
        chk(reqs == 0 && strobes == 1 && wr_q[0] === PAT, "locked write");
    endtask
    task automatic t_slow;
        op(0, 0, 0, 1, cbt_pkg::ACK_READY, 0, 1);
        chk(shq === 1'b1 && rdq[0] === cmd_addr, "slow shared");
    endtask
    // Pins and user side at rest after a reset
    task automatic t_idle;
        chk(bus_request_n === 1'b1 && addr_strobe_n === 1'b1 && bus_busy_n === 1'b1, "idle pins");
        chk(mux_addr_data_oe === 1'b0 && bus_busy_oe === 1'b0 && addr_strobe_oe === 1'b0, "idle enables");
        chk(cmd_ready === 1'b1 && done === 1'b0 && bus_grant_n === 1'b1, "idle user");
    endtask
    // Reset in mid-run drops the parked grant; the next op must arbitrate again
    task automatic t_reset;
        rstn = 1'b0;
        repeat (2) @(posedge clock);
        #1 rstn = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        t_idle();
        op(0, 0, 0, 0, cbt_pkg::ACK_READY, 0, 0);
        chk(reqs == 1 && rdv == 1 && rdq[0] === cmd_addr && res === cbt_pkg::RESULT_OK, "after reset");
    endtask
    // Main sequence
    initial begin
        {rstn, cmd_valid, cmd_write, cmd_burst, cmd_lock, snoop_slow, shr} = '0;
        {ack_kind, ack_beat, beats} = {cbt_pkg::ACK_READY, 3'h0, 3'h1};
        cmd_addr = 64'h1000;
        repeat (4) @(posedge clock);
        #1 rstn = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        t_idle();
        t_write();
        t_read();
        t_retry();
        t_error();
        t_lock();
        t_slow();
        t_reset();
        results();
    end
    // Watchdog
    initial begin
        #20000;
        bad_count++;
        $display("BAD %0t watchdog", $time);
        results();
    end
endmodule
bind cbt_master cbt_master_assertions chk_u (.clock, .rstn, .cmd_valid, .cmd_ready, .cmd_lock, .done,
    .done_result, .bus_request_n, .bus_busy_n, .addr_strobe_n, .mux_addr_data_oe, .ready_ack_n,
    .retry_ack_n, .error_ack_n, .bus_grant_n);
